/* srl_params.svh */
`ifndef SRL_PARAMS_SVH
`define SRL_PARAMS_SVH

// Register indices on the plain register port.
`define SRL_MAIN_IDX 4'h0
`define SRL_SRC_IDX 4'h1

// Reset values.
`define SRL_MAIN_RESET 8'h00
`define SRL_SRC_RESET 8'h00
`define SRL_RDATA_IDLE 8'h00

// Main control field positions.
`define SRL_MAIN_ENABLE_BIT 7
`define SRL_MAIN_DIV_HI 6
`define SRL_MAIN_DIV_LO 4
`define SRL_MAIN_TRUE_OE_BIT 3
`define SRL_MAIN_INV_OE_BIT 2
`define SRL_MAIN_SOFT_SET_BIT 1
`define SRL_MAIN_SOFT_RST_BIT 0

// Source enable field positions; bits 5 and 1 are reserved.
`define SRL_SRC_PIN_SET_BIT 7
`define SRL_SRC_CLK_SET_BIT 6
`define SRL_SRC_RSVD_HI_BIT 5
`define SRL_SRC_CMP_SET_BIT 4
`define SRL_SRC_PIN_RST_BIT 3
`define SRL_SRC_CLK_RST_BIT 2
`define SRL_SRC_RSVD_LO_BIT 1
`define SRL_SRC_CMP_RST_BIT 0

// Divider: select 0 gives a period of 4, select 7 a period of 512.
`define SRL_DIV_COUNT_RESET 9'h000
`define SRL_DIV_FULL_MASK 9'h1ff
`define SRL_DIV_MAX_SEL 3'h7
`define SRL_DIV_STEP 9'h001

`endif

/* srl_pkg.sv */
`default_nettype none

package srl_pkg;

	typedef logic [7:0] srl_byte_t;
	typedef logic [2:0] srl_div_sel_t;
	typedef logic [8:0] srl_div_count_t;

endpackage : srl_pkg

`default_nettype wire

/* srl_latch.sv */
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "srl_params.svh"

// Operation
// (R1) Latch state follows set and reset at once, with no clock edge in the path.
// (R2) Combined set and combined reset inputs are both active high.
// (R3) Set and reset together leave the latch reset.
// (R4) Writing one to the soft set bit pulses set for one clock.
// (R5) Writing one to the soft reset bit pulses reset for one clock.
// (R6) Soft pulse bits clear themselves and always read as zero.
// (R7) Divider pulses one clock wide every 4 to 512 clocks by select.
// (R8) Clock set enable routes the divider pulse to set.
// (R9) Clock reset enable routes the divider pulse to reset.
// (R10) Pin set enable lets a high input pin set the latch.
// (R11) Pin reset enable lets a high input pin reset the latch.
// (R12) Comparator set enable lets a high comparator output set the latch.
// (R13) Comparator reset enable lets a high comparator output reset the latch.
// (R14) True pin is driven with the state when enabled and latch enabled.
// (R15) Inverted pin is driven with the complement when enabled and latch enabled.
// (R16) Latch works only while its enable bit is one.
// (R17) Software keeps reserved source bits zero; they read back zero.
// (R18) Latch state is not guaranteed after reset; software initialises it.
// (R19) Software never enables one source for both set and reset.
// (R20) Set and reset are each the OR of their enabled sources.
// (R21) Divider counter is free running and restarts at reset.
module srl_latch #(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	// Latch sources
	input wire logic latch_input_pin_i,
	input wire logic synced_comparator_output_i,
	// Latch output pins
	output logic true_output_pin_o,
	output logic true_output_oe_o,
	output logic inverted_output_pin_o,
	output logic inverted_output_oe_o
);

	// Register decode
	logic sel_main;
	logic sel_src;
	logic wr_main;
	logic wr_src;

	assign sel_main = (reg_addr_i == ADDR_W'(`SRL_MAIN_IDX));
	assign sel_src = (reg_addr_i == ADDR_W'(`SRL_SRC_IDX));
	assign wr_main = reg_write_i && sel_main;
	assign wr_src = reg_write_i && sel_src;

	// Main control fields
	logic latch_enable;
	srl_pkg::srl_div_sel_t pulse_divider_select;
	logic true_output_enable;
	logic inverted_output_enable;
	logic soft_set_pulse;
	logic soft_reset_pulse;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			latch_enable <= 1'(`SRL_MAIN_RESET >> `SRL_MAIN_ENABLE_BIT);
			pulse_divider_select <= 3'(`SRL_MAIN_RESET >> `SRL_MAIN_DIV_LO);
			true_output_enable <= 1'b0;
			inverted_output_enable <= 1'b0;
		end
		else if (wr_main)
		begin
			latch_enable <= reg_wdata_i[`SRL_MAIN_ENABLE_BIT];
			pulse_divider_select <= reg_wdata_i[`SRL_MAIN_DIV_HI:`SRL_MAIN_DIV_LO];
			true_output_enable <= reg_wdata_i[`SRL_MAIN_TRUE_OE_BIT];
			inverted_output_enable <= reg_wdata_i[`SRL_MAIN_INV_OE_BIT];
		end
	end

	// The enables are formed at write time so that each pin enable is a
	// flip-flop of its own rather than a gate behind two flip-flops.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			true_output_oe_o <= 1'b0;
			inverted_output_oe_o <= 1'b0;
		end
		else if (wr_main)
		begin
			true_output_oe_o <= reg_wdata_i[`SRL_MAIN_ENABLE_BIT]
				& reg_wdata_i[`SRL_MAIN_TRUE_OE_BIT]; // [R14] [R16]
			inverted_output_oe_o <= reg_wdata_i[`SRL_MAIN_ENABLE_BIT]
				& reg_wdata_i[`SRL_MAIN_INV_OE_BIT]; // [R15] [R16]
		end
	end

	// Soft pulses last exactly one clock; a zero written has no effect.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			soft_set_pulse <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end
		else
		begin
			soft_set_pulse <= wr_main && reg_wdata_i[`SRL_MAIN_SOFT_SET_BIT]; // [R4] [R6]
			soft_reset_pulse <= wr_main && reg_wdata_i[`SRL_MAIN_SOFT_RST_BIT]; // [R5] [R6]
		end
	end

	// Source enables
	logic pin_set_enable;
	logic clock_set_enable;
	logic comparator_set_enable;
	logic pin_reset_enable;
	logic clock_reset_enable;
	logic comparator_reset_enable;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pin_set_enable <= 1'b0;
			clock_set_enable <= 1'b0;
			comparator_set_enable <= 1'b0;
			pin_reset_enable <= 1'b0;
			clock_reset_enable <= 1'b0;
			comparator_reset_enable <= 1'b0;
		end
		else if (wr_src)
		begin
			pin_set_enable <= reg_wdata_i[`SRL_SRC_PIN_SET_BIT];
			clock_set_enable <= reg_wdata_i[`SRL_SRC_CLK_SET_BIT];
			comparator_set_enable <= reg_wdata_i[`SRL_SRC_CMP_SET_BIT];
			pin_reset_enable <= reg_wdata_i[`SRL_SRC_PIN_RST_BIT];
			clock_reset_enable <= reg_wdata_i[`SRL_SRC_CLK_RST_BIT];
			comparator_reset_enable <= reg_wdata_i[`SRL_SRC_CMP_RST_BIT];
		end
	end

	// Periodic pulse divider
	srl_pkg::srl_div_count_t div_count;
	srl_pkg::srl_div_count_t div_mask;
	logic div_pulse;

	assign div_mask = `SRL_DIV_FULL_MASK >> (`SRL_DIV_MAX_SEL - pulse_divider_select);

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			div_count <= `SRL_DIV_COUNT_RESET; // [R21]
		else
			div_count <= div_count + `SRL_DIV_STEP; // [R21]
	end

	// A new select changes div_mask in the cycle after the write while the
	// count runs on, so the first period after a change may be short.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			div_pulse <= 1'b0;
		else
			div_pulse <= ((div_count & div_mask) == div_mask); // [R7]
	end

	// Combined latch inputs
	logic set_in;
	logic rst_in;

	assign set_in = soft_set_pulse
		| (clock_set_enable & div_pulse) // [R8]
		| (pin_set_enable & latch_input_pin_i) // [R10]
		| (comparator_set_enable & synced_comparator_output_i); // [R12] [R20]
	assign rst_in = soft_reset_pulse
		| (clock_reset_enable & div_pulse) // [R9]
		| (pin_reset_enable & latch_input_pin_i) // [R11]
		| (comparator_reset_enable & synced_comparator_output_i); // [R13] [R20]

	// Latch core
	logic latch_q;
	logic latch_now;

	// The stored bit only remembers the state between events; the visible
	// state reacts to set and reset in the same cycle, as a true latch does.
	always_comb
	begin
		if (!latch_enable)
			latch_now = latch_q; // [R16]
		else if (rst_in)
			latch_now = 1'b0; // [R2] [R3]
		else if (set_in)
			latch_now = 1'b1; // [R2]
		else
			latch_now = latch_q;
	end

	// The reset value is a simulation convenience only; software must not
	// rely on it and initialises the latch before enabling a pin.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			latch_q <= 1'b0; // [R18]
		else
			latch_q <= latch_now; // [R1]
	end

	assign true_output_pin_o = latch_now; // [R1] [R14]
	assign inverted_output_pin_o = ~latch_now; // [R15]

	// Register read-back, valid only in the cycle after the read strobe.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			reg_rdata_o <= `SRL_RDATA_IDLE;
		else if (reg_read_i && sel_main)
			reg_rdata_o <= {latch_enable, pulse_divider_select, true_output_enable,
				inverted_output_enable, 2'b00}; // [R6]
		else if (reg_read_i && sel_src)
			reg_rdata_o <= {pin_set_enable, clock_set_enable, 1'b0,
				comparator_set_enable, pin_reset_enable, clock_reset_enable,
				1'b0, comparator_reset_enable}; // [R17]
		else
			reg_rdata_o <= `SRL_RDATA_IDLE;
	end

	// Checks
	default clocking chk_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence soft_set_write_s;
		wr_main && reg_wdata_i[`SRL_MAIN_SOFT_SET_BIT];
	endsequence

	sequence soft_rst_write_s;
		wr_main && reg_wdata_i[`SRL_MAIN_SOFT_RST_BIT];
	endsequence

	sequence one_cycle_high_s(sig);
		sig ##1 !sig;
	endsequence

	sequence fast_div_run_s;
		(div_pulse && pulse_divider_select == 3'h0)
			##1 (pulse_divider_select == 3'h0)[*4];
	endsequence

	chk_reset_dominant: assert property ( // [R3]
		(latch_enable && set_in && rst_in) |-> !latch_now && !true_output_pin_o)
		else $error("set and reset together did not reset the latch");

	chk_set_immediate: assert property ( // [R1]
		(latch_enable && set_in && !rst_in) |-> latch_now ##1 latch_q)
		else $error("set did not take effect in the same cycle");

	chk_disabled_hold: assert property ( // [R16]
		!latch_enable |-> latch_now == latch_q)
		else $error("latch changed while disabled");

	chk_soft_set_pulse: assert property ( // [R4]
		soft_set_write_s |=> one_cycle_high_s(soft_set_pulse))
		else $error("soft set pulse not exactly one cycle");

	chk_soft_rst_pulse: assert property ( // [R5]
		soft_rst_write_s |=> one_cycle_high_s(soft_reset_pulse))
		else $error("soft reset pulse not exactly one cycle");

	chk_soft_reads_zero: assert property ( // [R6]
		(reg_read_i && sel_main) |=> reg_rdata_o[1:0] == 2'b00)
		else $error("soft pulse bits did not read zero");

	chk_div_period: assert property ( // [R7]
		fast_div_run_s |-> div_pulse)
		else $error("divider pulse missing after four cycles");

	chk_div_width: assert property ( // [R7]
		div_pulse |=> !div_pulse)
		else $error("divider pulse wider than one cycle");

	chk_clock_routes: assert property ( // [R8]
		(div_pulse && clock_set_enable) |-> set_in)
		else $error("divider pulse not routed to set");

	chk_clock_reset_route: assert property ( // [R9]
		(latch_enable && div_pulse && clock_reset_enable) |-> !latch_now)
		else $error("divider pulse did not reset the latch");

	chk_pin_routes: assert property ( // [R11]
		(latch_input_pin_i && pin_reset_enable) |-> rst_in)
		else $error("input pin not routed to reset");

	chk_cmp_set_route: assert property ( // [R12]
		(latch_enable && synced_comparator_output_i && comparator_set_enable
			&& !rst_in) |-> latch_now)
		else $error("comparator did not set the latch");

	chk_true_output: assert property ( // [R14]
		true_output_oe_o == (latch_enable && true_output_enable)
			&& true_output_pin_o == latch_now)
		else $error("true output pin or enable wrong");

	chk_inverted_output: assert property ( // [R15]
		inverted_output_oe_o == (latch_enable && inverted_output_enable)
			&& inverted_output_pin_o == !true_output_pin_o)
		else $error("inverted output pin or enable wrong");

	chk_reserved_zero: assert property ( // [R17]
		(reg_read_i && sel_src) |=> !reg_rdata_o[5] && !reg_rdata_o[1])
		else $error("reserved source bits not read as zero");

	// The four *_route checks below look at the visible state, so a broken OR term shows up here.
	chk_pin_set_route: assert property ( // [R10]
		(latch_enable && latch_input_pin_i && pin_set_enable && !rst_in) |-> latch_now)
		else $error("input pin did not set the latch");

	chk_pin_reset_route: assert property ( // [R11]
		(latch_enable && latch_input_pin_i && pin_reset_enable) |-> !latch_now)
		else $error("input pin did not reset the latch");

	chk_cmp_reset_route: assert property ( // [R13]
		(latch_enable && synced_comparator_output_i && comparator_reset_enable) |-> !latch_now)
		else $error("comparator did not reset the latch");

	chk_clock_set_route: assert property ( // [R8]
		(latch_enable && div_pulse && clock_set_enable && !rst_in) |-> latch_now)
		else $error("divider pulse did not set the latch");

	chk_idle_hold: assert property ( // [R20]
		(!set_in && !rst_in) |-> latch_now == latch_q)
		else $error("latch moved with no active input");

	chk_set_combined: assert property ( // [R20]
		(soft_set_pulse || (pin_set_enable && latch_input_pin_i)) |-> set_in)
		else $error("enabled set source missing from set input");

	chk_rst_combined: assert property ( // [R20]
		(soft_reset_pulse || (pin_reset_enable && latch_input_pin_i)) |-> rst_in)
		else $error("enabled reset source missing from reset input");

	chk_soft_set_clear: assert property ( // [R6]
		(soft_set_pulse && !(wr_main && reg_wdata_i[`SRL_MAIN_SOFT_SET_BIT])) |=> !soft_set_pulse)
		else $error("soft set pulse did not clear itself");

	chk_soft_rst_clear: assert property ( // [R6]
		(soft_reset_pulse && !(wr_main && reg_wdata_i[`SRL_MAIN_SOFT_RST_BIT]))
			|=> !soft_reset_pulse)
		else $error("soft reset pulse did not clear itself");

	chk_soft_set_zero: assert property ( // [R4]
		(wr_main && !reg_wdata_i[`SRL_MAIN_SOFT_SET_BIT]) |=> !soft_set_pulse)
		else $error("writing zero to soft set pulsed set");

	chk_soft_rst_zero: assert property ( // [R5]
		(wr_main && !reg_wdata_i[`SRL_MAIN_SOFT_RST_BIT]) |=> !soft_reset_pulse)
		else $error("writing zero to soft reset pulsed reset");

	chk_oe_when_off: assert property ( // [R16]
		(wr_main && !reg_wdata_i[`SRL_MAIN_ENABLE_BIT])
			|=> !true_output_oe_o && !inverted_output_oe_o)
		else $error("pin enable active with latch disabled");

	chk_div_count_step: assert property ( // [R21]
		1'b1 |=> div_count == $past(div_count) + `SRL_DIV_STEP)
		else $error("divider count did not advance by one");

	chk_divider_restart: assert property ( // [R21]
		@(posedge sys_clk_i) disable iff (1'b0)
		reset_i |=> div_count == 9'h000)
		else $error("divider did not restart at reset");

endmodule : srl_latch

`default_nettype wire

/* srl_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Stands for the comparator, the external input pin and the two output pads.
module srl_far_model (
	// Clock
	input wire logic sys_clk_i,
	// Source levels toward the latch
	output logic latch_input_pin_o,
	output logic synced_comparator_output_o,
	// Output pins from the latch
	input wire logic true_pin_i,
	input wire logic true_oe_i,
	input wire logic inv_pin_i,
	input wire logic inv_oe_i,
	output logic true_pad_o,
	output logic inv_pad_o
);
	logic true_last;
	logic inv_last;

	initial
	begin
		latch_input_pin_o = 1'b0;
		synced_comparator_output_o = 1'b0;
	end

	// An undriven pad shows the inverse of its last level, so a stale value never passes.
	always @(posedge sys_clk_i)
	begin
		if (true_oe_i)
			true_last <= true_pin_i;
		if (inv_oe_i)
			inv_last <= inv_pin_i;
	end
	assign true_pad_o = true_oe_i ? true_pin_i : ~true_last;
	assign inv_pad_o = inv_oe_i ? inv_pin_i : ~inv_last;

	// The comparator output arrives already synchronised, so levels move only after an edge.
	task automatic drive(input logic pin, input logic cmp);
		@(posedge sys_clk_i);
		latch_input_pin_o <= pin;
		synced_comparator_output_o <= cmp;
	endtask : drive
endmodule : srl_far_model

`default_nettype wire

/* srl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "srl_params.svh"

module testbench;
	logic sys_clk_i;
	logic reset_i;
	logic [3:0] reg_addr_i;
	srl_pkg::srl_byte_t reg_wdata_i;
	srl_pkg::srl_byte_t reg_rdata_o;
	logic reg_write_i;
	logic reg_read_i;
	logic lpin, cmp, tpin, toe, ipin, ioe, tpad, ipad;
	logic p, c, state;
	logic [31:0] rng;
	srl_pkg::srl_byte_t d;
	int err_total, total_checks, cycles, i, j, k, n;

	srl_latch #(.ADDR_W(4)) i_srl_latch (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .latch_input_pin_i(lpin),
		.synced_comparator_output_i(cmp), .true_output_pin_o(tpin), .true_output_oe_o(toe),
		.inverted_output_pin_o(ipin), .inverted_output_oe_o(ioe));
	srl_far_model i_srl_far_model (.sys_clk_i(sys_clk_i), .latch_input_pin_o(lpin),
		.synced_comparator_output_o(cmp), .true_pin_i(tpin), .true_oe_i(toe),
		.inv_pin_i(ipin), .inv_oe_i(ioe), .true_pad_o(tpad), .inv_pad_o(ipad));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			test_done();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs

	// Reset wins over set; with neither active the latch keeps its state.
	function automatic logic next_q(input logic q, input srl_pkg::srl_byte_t en,
		input logic pn, input logic cm);
		logic s;
		logic r;
		s = (en[7] & pn) | (en[4] & cm);
		r = (en[3] & pn) | (en[0] & cm);
		return r ? 1'b0 : (s ? 1'b1 : q);
	endfunction : next_q

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input srl_pkg::srl_byte_t v);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_write_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_write_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output srl_pkg::srl_byte_t v);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_read_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask : rd

	task automatic pins(input logic q);
		@(negedge sys_clk_i);
		chk("true_pad", {15'h0000, q}, {15'h0000, tpad});
		chk("inv_pad", {15'h0000, ~q}, {15'h0000, ipad});
	endtask : pins

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	initial
	begin
		reset_i = 1'b1;
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		reg_write_i = 1'b0;
		reg_read_i = 1'b0;
		err_total = 0;
		total_checks = 0;
		cycles = 0;
		rng = 32'hd8a9;
		repeat (8) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(`SRL_MAIN_IDX, d);
		chk("main_reset", 16'h0000, {8'h00, d});
		rd(`SRL_SRC_IDX, d);
		chk("src_reset", 16'h0000, {8'h00, d});
		rd(4'hf, d);
		chk("unmapped", 16'h0000, {8'h00, d});
		chk("oe_reset", 16'h0000, {14'h0000, toe, ioe});
		wr(`SRL_MAIN_IDX, 8'h81);
		wr(`SRL_MAIN_IDX, 8'h8e);
		pins(1'b1);
		rd(`SRL_MAIN_IDX, d);
		chk("main_read", 16'h008c, {8'h00, d});
		wr(`SRL_MAIN_IDX, 8'h8d);
		pins(1'b0);
		wr(`SRL_MAIN_IDX, 8'h8e);
		pins(1'b1);
		wr(`SRL_MAIN_IDX, 8'h8f);
		pins(1'b0);
		wr(`SRL_SRC_IDX, 8'h94);
		rd(`SRL_SRC_IDX, d);
		chk("src_read", 16'h0094, {8'h00, d});
		wr(`SRL_SRC_IDX, 8'h49);
		rd(`SRL_SRC_IDX, d);
		chk("src_read", 16'h0049, {8'h00, d});
		wr(`SRL_SRC_IDX, 8'h81);
		wr(`SRL_MAIN_IDX, 8'h8c);
		i_srl_far_model.drive(1'b1, 1'b1);
		pins(1'b0);
		i_srl_far_model.drive(1'b1, 1'b0);
		pins(1'b1);
		i_srl_far_model.drive(1'b0, 1'b0);
		pins(1'b1);
		p = 1'b0;
		c = 1'b0;
		state = 1'b1;
		// One source is never enabled for both set and reset at once.
		for (i = 0; i < 200; i++)
		begin
			rng = xs(rng);
			d = rng[7:0] & 8'h99;
			if (d[7] & d[3])
				d[3] = 1'b0;
			if (d[4] & d[0])
				d[0] = 1'b0;
			wr(`SRL_SRC_IDX, d);
			state = next_q(state, d, p, c);
			p = rng[8];
			c = rng[9];
			i_srl_far_model.drive(p, c);
			state = next_q(state, d, p, c);
			pins(state);
		end
		// Comparator set held high makes each divider reset pulse a one-cycle dip.
		for (k = 0; k < 8; k++)
		begin
			wr(`SRL_SRC_IDX, 8'h05);
			i_srl_far_model.drive(1'b0, 1'b1);
			wr(`SRL_SRC_IDX, 8'h14);
			wr(`SRL_MAIN_IDX, {1'b1, k[2:0], 4'hc});
			n = 4 << k;
			j = 0;
			// The first pulse after the select write may come early, as the count runs on.
			repeat (2) @(negedge sys_clk_i);
			while (tpad !== 1'b0 && j < 1100)
			begin
				@(negedge sys_clk_i);
				j++;
			end
			@(negedge sys_clk_i);
			chk("pulse_width", 16'h0001, {15'h0000, tpad});
			j = 1;
			while (tpad !== 1'b0 && j < 1100)
			begin
				@(negedge sys_clk_i);
				j++;
			end
			chk("div_period", n[15:0], j[15:0]);
		end
		i_srl_far_model.drive(1'b0, 1'b0);
		wr(`SRL_SRC_IDX, 8'h40);
		wr(`SRL_MAIN_IDX, 8'h8d);
		repeat (6) @(negedge sys_clk_i);
		chk("clock_set", 16'h0001, {15'h0000, tpad});
		wr(`SRL_SRC_IDX, 8'h08);
		wr(`SRL_MAIN_IDX, 8'h0c);
		@(negedge sys_clk_i);
		chk("oe_disabled", 16'h0000, {14'h0000, toe, ioe});
		i_srl_far_model.drive(1'b1, 1'b0);
		i_srl_far_model.drive(1'b0, 1'b0);
		wr(`SRL_MAIN_IDX, 8'h8c);
		pins(1'b1);
		reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(`SRL_MAIN_IDX, d);
		chk("main_rerun", 16'h0000, {8'h00, d});
		chk("oe_rerun", 16'h0000, {14'h0000, toe, ioe});
		test_done();
	end
endmodule : testbench

`default_nettype wire
